// File: codec_reset_and_startup_control.sv
// Reset gate, soft reset / identity word, sequencer launch and busy tracking over AXI4-Lite
// Function
// RULE_01 - While power-on reset holds, stay in reset and drop every control write.
// RULE_02 - Release power-on reset only when all three supply-good levels are true.
// RULE_03 - Power-on reset lasts at least 100 ns even with instant supplies.
// RULE_04 - Reassert power-on reset as soon as any supply-good level drops.
// RULE_05 - Writing 0100h to launch register 49h starts sequencer at step 0.
// RULE_06 - Writing 012Ah to launch register starts sequencer at step 42.
// RULE_07 - Ignore host writes while the sequencer runs.
// RULE_08 - Busy flag reads 1 while a sequence runs, 0 once done.
// RULE_09 - Host waits fixed time or polls busy before continuing.
// RULE_10 - Host sets paths and gains before launching a default start-up.
// RULE_11 - Host start-up order: DACs, routes, launch 0, wait, unmute.
// RULE_12 - Host shut-down order: mute, launch 42, wait, clear routes, DACs.
// RULE_13 - Any write to register 0 resets control registers to defaults.
// RULE_14 - Soft reset leaves sequencer step storage 3000h-31FFh unchanged.
// RULE_15 - Register 0 reads the fixed 16-bit identity code.
// RULE_16 - Busy state also drives a pin and an interrupt source.
// RULE_17 - Combined reset asserts asynchronously, releases through two-stage synchroniser.
`timescale 1ns/1ps
`default_nettype none
module codec_reset_and_startup_control
	import codec_reset_pkg::*;
#(
	parameter logic [15:0] ID_CODE = 16'h5a5a, // Arbitrary identity value
	parameter int STEP_CYCLES = 16
)
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic analog_supply_one_good_in,
	input wire logic analog_supply_two_good_in,
	input wire logic core_supply_good_in,
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic por_active_out,
	output logic sequencer_busy_pin_out,
	output logic [7:0] sequencer_step_out,
	output logic irq_out
);
	import codec_reset_pkg::*;

	// ------------------------------------------------------------
	// Power-on reset gate
	// ------------------------------------------------------------
	logic sup1_ok;
	logic sup2_ok;
	logic core_ok;
	logic all_ok;
	logic [POR_CNT_W-1:0] por_cnt_q;
	logic por_done_q;
	logic por_active_q;
	logic nrst_por;
	logic soft_rst_q;
	logic nrst_req;
	logic nrst_sys;

	supply_sync u_sync_a1 (.clk_in(clk_in), .nrst_in(nrst_in),
		.level_in(analog_supply_one_good_in), .level_out(sup1_ok));
	supply_sync u_sync_a2 (.clk_in(clk_in), .nrst_in(nrst_in),
		.level_in(analog_supply_two_good_in), .level_out(sup2_ok));
	supply_sync u_sync_core (.clk_in(clk_in), .nrst_in(nrst_in),
		.level_in(core_supply_good_in), .level_out(core_ok));

	assign all_ok = sup1_ok & sup2_ok & core_ok; // RULE_02

	// Counter restarts on any drop, so a glitching supply never shortens the period
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			por_cnt_q <= '0;
			por_done_q <= 1'b0;
		end
		else if (!all_ok)
		begin
			por_cnt_q <= '0; // RULE_04
			por_done_q <= 1'b0; // RULE_04
		end
		else if (por_cnt_q < POR_CNT_W'(POR_MIN_CYC))
			por_cnt_q <= por_cnt_q + POR_CNT_W'(1); // RULE_03
		else
			por_done_q <= 1'b1; // RULE_02
	end

	assign nrst_por = nrst_in & por_done_q;
	assign nrst_req = nrst_por & ~soft_rst_q;

	reset_sync u_rst_sync (.clk_in(clk_in), .nrst_req_in(nrst_req), .nrst_out(nrst_sys)); // RULE_17

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			por_active_q <= 1'b1;
		else
			por_active_q <= ~nrst_sys; // RULE_01
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_held_q;
	logic w_held_q;
	logic [15:0] aw_idx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wr_fire;
	logic wr_accept;
	logic seq_running;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [15:0] ar_idx;
	logic [15:0] launch_word;

	// Bus stays alive under soft reset so the writer of register 0 gets its answer
	assign aw_take = s_axi_awvalid_in & ~aw_held_q;
	assign w_take = s_axi_wvalid_in & ~w_held_q;
	assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
	// Writes during soft reset or a running sequence are answered but dropped
	assign wr_accept = wr_fire & nrst_sys & ~seq_running; // RULE_01 RULE_07
	assign ar_take = s_axi_arvalid_in & ~rvalid_q;
	assign ar_idx = s_axi_araddr_in[ADDR_W+BYTE_SHIFT-1:BYTE_SHIFT];
	assign launch_word = wdata_q[15:0];

	always_ff @(posedge clk_in or negedge nrst_por)
	begin
		if (!nrst_por)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_idx_q <= '0;
			wdata_q <= ZERO_WORD;
			wstrb_q <= '0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_held_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr_in[ADDR_W+BYTE_SHIFT-1:BYTE_SHIFT];
			end
			else if (wr_fire)
				aw_held_q <= 1'b0;
			if (w_take)
			begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata_in;
				wstrb_q <= s_axi_wstrb_in;
			end
			else if (wr_fire)
				w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_por)
	begin
		if (!nrst_por)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= RESP_OKAY;
		end
		else if (s_axi_bready_in)
			bvalid_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic wr_reg0;
	logic wr_launch;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic wr_pin_ctrl;
	logic wr_step;
	logic launch_start;
	logic launch_stop;
	logic wr_low_lanes;

	assign wr_low_lanes = wstrb_q[0] & wstrb_q[1];
	assign wr_reg0 = wr_fire & nrst_sys & (aw_idx_q == IDX_SOFT_RESET_ID); // RULE_13
	assign wr_launch = wr_accept & (aw_idx_q == IDX_SEQ_LAUNCH) & wr_low_lanes;
	assign launch_start = wr_launch & (launch_word == LAUNCH_START_CMD); // RULE_05
	assign launch_stop = wr_launch & (launch_word == LAUNCH_STOP_CMD); // RULE_06
	assign wr_irq_stat = wr_accept & (aw_idx_q == IDX_IRQ_STATUS);
	assign wr_irq_mask = wr_accept & (aw_idx_q == IDX_IRQ_MASK);
	assign wr_pin_ctrl = wr_accept & (aw_idx_q == IDX_PIN_CTRL);
	assign wr_step = wr_accept & (aw_idx_q >= IDX_STEP_LO) & (aw_idx_q <= IDX_STEP_HI);

	// Soft reset pulses the combined reset; the bus answer is already on its way
	always_ff @(posedge clk_in or negedge nrst_por)
	begin
		if (!nrst_por)
			soft_rst_q <= 1'b0;
		else
			soft_rst_q <= wr_reg0 & ~seq_running; // RULE_13 RULE_07
	end

	// ------------------------------------------------------------
	// Step storage, kept across soft reset
	// ------------------------------------------------------------
	logic [15:0] step_mem [STEP_DEPTH];
	logic [STEP_AW-1:0] step_waddr;

	assign step_waddr = aw_idx_q[STEP_AW-1:0];

	// No reset term: stored sequences survive soft reset
	always_ff @(posedge clk_in)
	begin
		if (wr_step)
			step_mem[step_waddr] <= wdata_q[15:0]; // RULE_14
	end

	// ------------------------------------------------------------
	// Sequencer launch and busy tracking
	// ------------------------------------------------------------
	seq_state_t seq_q;
	seq_state_t seq_d;
	logic [7:0] step_q;
	logic [7:0] step_d;
	logic [7:0] end_step_q;
	logic [7:0] end_step_d;
	logic [7:0] dwell_q;
	logic [7:0] dwell_d;
	logic seq_done;

	assign seq_running = (seq_q == SEQ_RUN);
	// Step engine itself lives elsewhere; each step is modelled as a fixed dwell
	assign seq_done = seq_running & (dwell_q == 8'(STEP_CYCLES - 1)) & (step_q == end_step_q);

	always_comb
	begin
		seq_d = seq_q;
		step_d = step_q;
		end_step_d = end_step_q;
		dwell_d = dwell_q;
		unique case (seq_q)
			SEQ_IDLE:
			begin
				if (launch_start | launch_stop)
				begin
					seq_d = SEQ_RUN;
					step_d = launch_start ? STEP_IDX_START : STEP_IDX_STOP; // RULE_05 RULE_06
					end_step_d = launch_start ? STEP_IDX_STOP - 8'h01 : STEP_IDX_STOP + 8'h07;
					dwell_d = '0;
				end
			end
			SEQ_RUN:
			begin
				if (seq_done)
					seq_d = SEQ_DONE; // RULE_08
				else if (dwell_q == 8'(STEP_CYCLES - 1))
				begin
					dwell_d = '0;
					step_d = step_q + 8'h01;
				end
				else
					dwell_d = dwell_q + 8'h01;
			end
			SEQ_DONE:
				seq_d = SEQ_IDLE;
			default:
				seq_d = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_sys)
	begin
		if (!nrst_sys)
		begin
			seq_q <= SEQ_IDLE;
			step_q <= '0;
			end_step_q <= '0;
			dwell_q <= '0;
		end
		else
		begin
			seq_q <= seq_d;
			step_q <= step_d;
			end_step_q <= end_step_d;
			dwell_q <= dwell_d;
		end
	end

	// ------------------------------------------------------------
	// Interrupts and pin routing
	// ------------------------------------------------------------
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic [IRQ_W-1:0] irq_set;
	logic pin_route_q;
	logic busy_pin_q;
	logic irq_q;

	assign irq_set = {launch_start | launch_stop, seq_done}; // RULE_16

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_in or negedge nrst_sys)
	begin
		if (!nrst_sys)
		begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
			pin_route_q <= 1'b0;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~(wr_irq_stat ? wdata_q[IRQ_W-1:0] : '0)) | irq_set;
			if (wr_irq_mask)
				irq_mask_q <= wdata_q[IRQ_W-1:0];
			if (wr_pin_ctrl)
				pin_route_q <= wdata_q[BUSY_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge nrst_sys)
	begin
		if (!nrst_sys)
		begin
			busy_pin_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			busy_pin_q <= pin_route_q & seq_running; // RULE_16
			irq_q <= |(irq_stat_q & irq_mask_q); // RULE_16
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_hit;

	assign rd_hit = (ar_idx == IDX_SOFT_RESET_ID) | (ar_idx == IDX_SEQ_LAUNCH)
		| (ar_idx == IDX_SEQ_STATUS) | (ar_idx == IDX_IRQ_STATUS)
		| (ar_idx == IDX_IRQ_MASK) | (ar_idx == IDX_PIN_CTRL);
	assign rd_word =
		(ar_idx == IDX_SOFT_RESET_ID) ? {16'h0000, ID_CODE} : // RULE_15
		(ar_idx == IDX_SEQ_STATUS) ? {31'h00000000, seq_running} : // RULE_08
		(ar_idx == IDX_IRQ_STATUS) ? {30'h00000000, irq_stat_q} :
		(ar_idx == IDX_IRQ_MASK) ? {30'h00000000, irq_mask_q} :
		(ar_idx == IDX_PIN_CTRL) ? {31'h00000000, pin_route_q} : ZERO_WORD;

	always_ff @(posedge clk_in or negedge nrst_por)
	begin
		if (!nrst_por)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= ZERO_WORD;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_q <= rd_word;
		end
		else if (s_axi_rready_in)
			rvalid_q <= 1'b0;
	end

	assign s_axi_awready_out = ~aw_held_q;
	assign s_axi_wready_out = ~w_held_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = ~rvalid_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rdata_out = rdata_q;
	assign por_active_out = por_active_q;
	assign sequencer_busy_pin_out = busy_pin_q;
	assign sequencer_step_out = step_q;
	assign irq_out = irq_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_launch;
		launch_start | launch_stop;
	endsequence
	sequence s_running;
		seq_running;
	endsequence

	a_busy_after_launch: assert property (@(posedge clk_in) disable iff (!nrst_sys)
		s_launch |=> s_running) // RULE_08
		else $error("busy flag not set after launch");
	a_start_step_zero: assert property (@(posedge clk_in) disable iff (!nrst_sys)
		launch_start |=> step_q == STEP_IDX_START) // RULE_05
		else $error("start sequence not at step zero");
	a_stop_step_index: assert property (@(posedge clk_in) disable iff (!nrst_sys)
		launch_stop |=> step_q == STEP_IDX_STOP) // RULE_06
		else $error("stop sequence not at step 42");
	a_busy_write_drop: assert property (@(posedge clk_in) disable iff (!nrst_por)
		seq_running |-> !wr_accept) // RULE_07
		else $error("write accepted while sequencer busy");
	a_reset_write_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!nrst_sys |-> !wr_accept && !wr_step) // RULE_01
		else $error("write accepted during reset");
	a_supply_drop_reset: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!all_ok |=> !por_done_q) // RULE_04
		else $error("power-on reset not reasserted");
	a_por_min_period: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$rose(por_done_q) |-> $past(all_ok, 4) && $past(all_ok, 2)) // RULE_03
		else $error("power-on reset released too early");
	a_soft_reset_hit: assert property (@(posedge clk_in) disable iff (!nrst_por)
		wr_reg0 && !seq_running |=> ##[1:2] !nrst_sys) // RULE_13 RULE_17
		else $error("soft reset did not reach system reset");
	a_id_readback: assert property (@(posedge clk_in) disable iff (!nrst_por)
		ar_take && ar_idx == IDX_SOFT_RESET_ID |=> rdata_q[15:0] == ID_CODE) // RULE_15
		else $error("identity read wrong");
endmodule
`default_nettype wire

// File: codec_reset_pkg.sv
// Package: register map, field layouts and timing constants for reset and start-up control
package codec_reset_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int POR_MIN_NS = 100;
	// Least time rounds up, never below one cycle
	localparam int POR_MIN_CYC_RAW = (POR_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int POR_MIN_CYC = (POR_MIN_CYC_RAW < 1) ? 1 : POR_MIN_CYC_RAW;
	localparam int POR_CNT_W = 4;

	// Register indices (printed offsets), byte address is four times the index
	localparam logic [15:0] IDX_SOFT_RESET_ID = 16'h0000;
	localparam logic [15:0] IDX_SEQ_LAUNCH = 16'h0049;
	localparam logic [15:0] IDX_SEQ_STATUS = 16'h004a;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h0080;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h0081;
	localparam logic [15:0] IDX_PIN_CTRL = 16'h0082;
	localparam logic [15:0] IDX_STEP_LO = 16'h3000;
	localparam logic [15:0] IDX_STEP_HI = 16'h31ff;
	localparam int ADDR_W = 16;
	localparam int BYTE_SHIFT = 2;

	localparam logic [15:0] LAUNCH_START_CMD = 16'h0100;
	localparam logic [15:0] LAUNCH_STOP_CMD = 16'h012a;
	localparam logic [7:0] STEP_IDX_START = 8'h00;
	localparam logic [7:0] STEP_IDX_STOP = 8'h2a;
	localparam int STEP_DEPTH = 512;
	localparam int STEP_AW = 9;

	// Status bit positions
	localparam int BUSY_BIT = 0;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_START_BIT = 1;
	localparam int IRQ_W = 2;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;

	typedef enum logic [1:0]
	{
		SEQ_IDLE = 2'b00,
		SEQ_RUN = 2'b01,
		SEQ_DONE = 2'b10
	} seq_state_t;
endpackage

// File: host_model.sv
// Host processor model: AXI4-Lite master, one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input wire logic clk_in,
	output logic [31:0] awaddr_out,
	output logic awvalid_out,
	input wire logic awready_in,
	output logic [31:0] wdata_out,
	output logic wvalid_out,
	input wire logic wready_in,
	output logic bready_out,
	input wire logic bvalid_in,
	output logic [31:0] araddr_out,
	output logic arvalid_out,
	input wire logic arready_in,
	output logic rready_out,
	input wire logic rvalid_in,
	input wire logic [31:0] rdata_in
);
	initial
	begin
		{awaddr_out, wdata_out, araddr_out} = '0;
		{awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
	end

	// Handshakes judged at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [15:0] idx, input logic [15:0] val);
		logic aw_f, w_f, b_f;
		begin
			@(posedge clk_in);
			awaddr_out <= {14'h0, idx, 2'b00};
			wdata_out <= {16'h0, val};
			{awvalid_out, wvalid_out, bready_out} <= 3'b111;
			do
			begin
				@(negedge clk_in);
				aw_f = awvalid_out && awready_in;
				w_f = wvalid_out && wready_in;
				@(posedge clk_in);
				// Released payload flips so a stale value is never trusted
				if (aw_f)
				begin
					awvalid_out <= 1'b0;
					awaddr_out <= ~awaddr_out;
				end
				if (w_f)
				begin
					wvalid_out <= 1'b0;
					wdata_out <= ~wdata_out;
				end
			end while (awvalid_out || wvalid_out);
			do
			begin
				@(negedge clk_in);
				b_f = bvalid_in;
				@(posedge clk_in);
			end while (!b_f);
			bready_out <= 1'b0;
		end
	endtask

	task automatic rd(input logic [15:0] idx, output logic [31:0] d);
		logic f;
		begin
			@(posedge clk_in);
			araddr_out <= {14'h0, idx, 2'b00};
			{arvalid_out, rready_out} <= 2'b11;
			do
			begin
				@(negedge clk_in);
				f = arvalid_out && arready_in;
				@(posedge clk_in);
			end while (!f);
			arvalid_out <= 1'b0;
			araddr_out <= ~araddr_out;
			do
			begin
				@(negedge clk_in);
				f = rvalid_in;
				d = rdata_in;
				@(posedge clk_in);
			end while (!f);
			rready_out <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// File: reset_sync.sv
// Reset combiner: asynchronous assert, synchronous release through two flops
`timescale 1ns/1ps
`default_nettype none
module reset_sync
(
	input wire logic clk_in,
	input wire logic nrst_req_in,
	output logic nrst_out
);
	logic stage_q;
	logic out_q;

	always_ff @(posedge clk_in or negedge nrst_req_in)
	begin
		if (!nrst_req_in)
		begin
			stage_q <= 1'b0;
			out_q <= 1'b0;
		end
		else
		begin
			stage_q <= 1'b1;
			out_q <= stage_q;
		end
	end

	assign nrst_out = out_q;
endmodule
`default_nettype wire

// File: supply_sync.sv
// Three-flop synchroniser for a supply-good level; a change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module supply_sync
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic level_in,
	output logic level_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic out_q;

	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			out_q <= 1'b0;
		end
		else
		begin
			s1_q <= level_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				out_q <= s3_q;
		end
	end

	assign level_out = out_q;
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for reset gate, identity word and sequencer launch
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			bad_count++; \
			$display("MISMATCH %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb;
	import codec_reset_pkg::*;
	localparam logic [15:0] ID = 16'h3c3c; // Arbitrary identity value
	localparam logic [33:0] ALL = '1;
	logic clk_in, nrst_in, awvalid, awready, wvalid, wready, bready, bvalid;
	logic arvalid, arready, rready, rvalid, por, bpin, irq;
	logic [2:0] sup;
	logic [1:0] rresp;
	logic [7:0] step;
	logic [31:0] awaddr, wdata, araddr, rdata, d, seed;
	logic [33:0] exp_q[$], msk_q[$];
	logic [33:0] got_v, exp_v, msk_v;
	int bad_count, comparisons, n, k;

	codec_reset_and_startup_control #(.ID_CODE(ID), .STEP_CYCLES(16)) dut_u
	(
		.clk_in(clk_in), .nrst_in(nrst_in),
		.analog_supply_one_good_in(sup[0]), .analog_supply_two_good_in(sup[1]),
		.core_supply_good_in(sup[2]),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .por_active_out(por),
		.sequencer_busy_pin_out(bpin), .sequencer_step_out(step), .irq_out(irq)
	);

	host_model host_u
	(
		.clk_in(clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
		.wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready), .bready_out(bready),
		.bvalid_in(bvalid), .araddr_out(araddr), .arvalid_out(arvalid),
		.arready_in(arready), .rready_out(rready), .rvalid_in(rvalid), .rdata_in(rdata)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// Read results are matched against the oldest note
	// Pop once into locals: the macro reads its arguments more than once
	always @(negedge clk_in)
		if (rvalid && rready && exp_q.size() > 0)
		begin
			msk_v = msk_q.pop_front();
			exp_v = exp_q.pop_front() & msk_v;
			got_v = {rresp, rdata} & msk_v;
			`CHK("read", exp_v, got_v)
		end

	task automatic rx(input logic [15:0] idx, input logic [33:0] e, input logic [33:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		host_u.rd(idx, d);
	endtask

	task automatic wait_por(input logic v, input int lim);
		n = 0;
		do
		begin
			@(negedge clk_in);
			n++;
		end while (por !== v && n < lim);
	endtask

	task automatic wait_idle();
		k = 0;
		do
		begin
			rx(IDX_SEQ_STATUS, '0, '0);
			k++;
		end while (d[BUSY_BIT] !== 1'b0 && k < 300);
		`CHK("busy_clear", 1'b0, d[BUSY_BIT])
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		#(25 * 30000);
		bad_count++;
		close_out();
	end

	initial
	begin
		nrst_in = 1'b0;
		sup = 3'b111;
		seed = $urandom(78);
		repeat (8) @(posedge clk_in);
		nrst_in <= 1'b1;
		wait_por(1'b0, 100);
		`CHK("por_len", 1'b1, n >= POR_MIN_CYC)
		`CHK("por_rel", 1'b0, por)
		rx(IDX_SOFT_RESET_ID, {RESP_OKAY, 16'h0, ID}, ALL);
		rx(16'h0007, {RESP_SLVERR, ZERO_WORD}, ALL);
		$display("test id done");
		host_u.wr(IDX_PIN_CTRL, 16'h0001);
		host_u.wr(IDX_IRQ_MASK, 16'h0003);
		host_u.wr(16'h0003, 16'h0003);
		host_u.wr(16'h002d, 16'h0100);
		host_u.wr(16'h002e, 16'h0100);
		host_u.wr(IDX_SEQ_LAUNCH, LAUNCH_START_CMD);
		@(negedge clk_in);
		`CHK("step_start", STEP_IDX_START, step)
		`CHK("busy_pin", 1'b1, bpin)
		rx(IDX_SEQ_STATUS, 34'h1, 34'h1);
		host_u.wr(IDX_PIN_CTRL, 16'h0000);
		wait_idle();
		rx(IDX_PIN_CTRL, {RESP_OKAY, 32'h1}, ALL);
		host_u.wr(16'h000a, 16'h0000);
		@(negedge clk_in);
		`CHK("irq_done", 1'b1, irq)
		`CHK("busy_pin_off", 1'b0, bpin)
		host_u.wr(IDX_IRQ_MASK, 16'h0000);
		repeat (2) @(negedge clk_in);
		`CHK("irq_masked", 1'b0, irq)
		host_u.wr(IDX_IRQ_MASK, 16'h0003);
		repeat (2) @(negedge clk_in);
		`CHK("irq_unmask", 1'b1, irq)
		host_u.wr(IDX_IRQ_STATUS, 16'h0003);
		repeat (2) @(negedge clk_in);
		`CHK("irq_clear", 1'b0, irq)
		$display("test start done");
		host_u.wr(16'h000a, 16'h0004);
		host_u.wr(IDX_SEQ_LAUNCH, LAUNCH_STOP_CMD);
		@(negedge clk_in);
		`CHK("step_stop", STEP_IDX_STOP, step)
		wait_idle();
		host_u.wr(16'h002d, 16'h0000);
		host_u.wr(16'h002e, 16'h0000);
		host_u.wr(16'h0003, 16'h0000);
		$display("test stop done");
		host_u.wr(IDX_SOFT_RESET_ID, seed[15:0]);
		repeat (4) @(negedge clk_in);
		wait_por(1'b0, 50);
		rx(IDX_IRQ_MASK, {RESP_OKAY, 32'h0}, ALL);
		rx(IDX_PIN_CTRL, {RESP_OKAY, 32'h0}, ALL);
		rx(IDX_SOFT_RESET_ID, {RESP_OKAY, 16'h0, ID}, ALL);
		$display("test soft reset done");
		host_u.wr(IDX_PIN_CTRL, 16'h0001);
		k = $urandom_range(2, 0);
		@(posedge clk_in);
		sup[k] <= 1'b0;
		wait_por(1'b1, 10);
		`CHK("por_drop", 1'b1, por)
		repeat (20) @(negedge clk_in);
		`CHK("por_held", 1'b1, por)
		@(posedge clk_in);
		sup[k] <= 1'b1;
		wait_por(1'b0, 100);
		`CHK("por_back", 1'b0, por)
		rx(IDX_PIN_CTRL, {RESP_OKAY, 32'h0}, ALL);
		$display("test supply drop done");
		close_out();
	end
endmodule
`default_nettype wire
